// [logic/bit_xfer_pkg.sv]
package bit_xfer_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths.
   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 8;
   localparam int IO_ADDR_W = 6;
   localparam int RF_IDX_W  = 4;
   localparam int RF_DEPTH  = 16;
   localparam int OP_W      = 6;
   localparam int APB_AW    = 8;
   localparam int BIT_IDX_W = 3;
   localparam int PTR_SEL_W = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Command word field positions.
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_RD_LSB  = 8;
   localparam int CMD_RR_LSB  = 12;
   localparam int CMD_BIT_LSB = 16;
   localparam int CMD_PTR_LSB = 20;
   localparam int CMD_K_LSB   = 24;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses).
   localparam logic [APB_AW-1:0] OFF_CMD     = 8'h00;
   localparam logic [APB_AW-1:0] OFF_STATE   = 8'h04;
   localparam logic [APB_AW-1:0] OFF_FLAGS   = 8'h08;
   localparam logic [APB_AW-1:0] OFF_XPTR    = 8'h0c;
   localparam logic [APB_AW-1:0] OFF_YPTR    = 8'h10;
   localparam logic [APB_AW-1:0] OFF_ZPTR    = 8'h14;
   localparam logic [APB_AW-1:0] OFF_SP      = 8'h18;
   localparam logic [APB_AW-1:0] OFF_RF_BASE = 8'h40;
   localparam logic [APB_AW-1:0] RF_SEL_MASK = 8'hc3;
   localparam int                RF_IDX_LSB  = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Status flag positions and reset values.
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;
   localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] PTR_RESET   = 8'h00;
   localparam logic [ADDR_W-1:0] PTR_STEP    = 8'h01;

   // State word bit positions.
   localparam int STATE_BUSY    = 0;
   localparam int STATE_ILLEGAL = 1;
   localparam int STATE_LEN_LSB = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Opcodes.
   localparam logic [OP_W-1:0] OP_IDLE    = 6'h00;
   localparam logic [OP_W-1:0] OP_COPY    = 6'h01;
   localparam logic [OP_W-1:0] OP_IMM     = 6'h02;
   localparam logic [OP_W-1:0] OP_RP      = 6'h03;
   localparam logic [OP_W-1:0] OP_RP_INC  = 6'h04;
   localparam logic [OP_W-1:0] OP_RP_DEC  = 6'h05;
   localparam logic [OP_W-1:0] OP_WP      = 6'h06;
   localparam logic [OP_W-1:0] OP_WP_INC  = 6'h07;
   localparam logic [OP_W-1:0] OP_WP_DEC  = 6'h08;
   localparam logic [OP_W-1:0] OP_RDIR    = 6'h09;
   localparam logic [OP_W-1:0] OP_WDIR    = 6'h0a;
   localparam logic [OP_W-1:0] OP_IN      = 6'h0b;
   localparam logic [OP_W-1:0] OP_OUT     = 6'h0c;
   localparam logic [OP_W-1:0] OP_PUSH    = 6'h0d;
   localparam logic [OP_W-1:0] OP_POP     = 6'h0e;
   localparam logic [OP_W-1:0] OP_IOSET   = 6'h0f;
   localparam logic [OP_W-1:0] OP_IOCLR   = 6'h10;
   localparam logic [OP_W-1:0] OP_TSTORE  = 6'h11;
   localparam logic [OP_W-1:0] OP_TLOAD   = 6'h12;
   localparam logic [OP_W-1:0] OP_FSET    = 6'h13;
   localparam logic [OP_W-1:0] OP_FCLR    = 6'h14;
   localparam logic [OP_W-1:0] OP_SLEEP   = 6'h15;
   localparam logic [OP_W-1:0] OP_WDOG    = 6'h16;
   localparam logic [OP_W-1:0] OP_HALT    = 6'h17;

   localparam logic [PTR_SEL_W-1:0] PTR_X = 2'h0;
   localparam logic [PTR_SEL_W-1:0] PTR_Y = 2'h1;
   localparam logic [PTR_SEL_W-1:0] PTR_Z = 2'h2;

   typedef enum logic [3:0] {
      S_IDLE  = 4'h1,
      S_FETCH = 4'h2,
      S_EXEC1 = 4'h4,
      S_EXEC2 = 4'h8
   } exec_state_type;

   function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_IDX_W-1:0] idx);
      bit_mask = 8'h01 << idx;
   endfunction

endpackage

// [logic/gp_regfile.sv]
`timescale 1ns/100ps
module gp_regfile
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
)
(
   // Clock
   input  wire logic             clk,
   // Write port
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // Read ports, data one cycle after address
   input  wire logic [AW-1:0]    raddr_a,
   input  wire logic [AW-1:0]    raddr_b,
   output logic      [WIDTH-1:0] rdata_a,
   output logic      [WIDTH-1:0] rdata_b
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end

endmodule

// [logic/op_timing.sv]
`timescale 1ns/100ps
module op_timing
   import bit_xfer_pkg::*;
(
   // Opcode
   input  wire logic [OP_W-1:0] op,
   // Timing class
   output logic                 two_cycle,
   output logic                 known
);

   // Pointer loads that move the pointer, pre-decrement stores and stack
   // operations take two execute cycles; all others take one.
   assign two_cycle = (op == OP_RP_INC) | (op == OP_RP_DEC) |          // [RULE9] [RULE10]
                      (op == OP_WP_DEC) | (op == OP_PUSH) |            // [RULE12] [RULE16]
                      (op == OP_POP);                                  // [RULE17]
   assign known     = (op <= OP_HALT);

endmodule

// [logic/bit_xfer_exec.sv]
`timescale 1ns/100ps
// Operation
// RULE1 - io_bit_set sets I/O bit, one cycle
// RULE2 - io_bit_clear clears I/O bit, one cycle
// RULE3 - reg_bit_to_t copies register bit into T
// RULE4 - t_to_reg_bit writes T into register bit
// RULE5 - Flag set instructions set one flag
// RULE6 - Flag clear instructions clear one flag
// RULE7 - Half carry set and clear, one cycle
// RULE8 - Overflow flag set and clear, one cycle
// RULE9 - Pointer read one cycle; post-increment two
// RULE10 - Pre-decrement read: decrement, then load
// RULE11 - Pointer store one cycle, optional post-increment
// RULE12 - Pre-decrement store: decrement, then store, two
// RULE13 - Direct read loads Rd, one cycle
// RULE14 - Direct write stores Rr, one cycle
// RULE15 - I/O in and out, one cycle each
// RULE16 - Push stores Rr on stack, two cycles
// RULE17 - Pop loads Rd from stack, two cycles
// RULE18 - Sleep takes one cycle, requests low power
// RULE19 - Watchdog restart takes one cycle
// RULE20 - Debug halt takes one cycle, requests break
// RULE21 - Copy, immediate, idle: one cycle, no flags
// RULE22 - Status bit clear clears selected flag only
module bit_xfer_exec
   import bit_xfer_pkg::*;
#(
   parameter logic [ADDR_W-1:0] SP_RESET = 8'hff
)
(
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [APB_AW-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Data memory and stack
   output logic      [ADDR_W-1:0]    dmem_addr,
   output logic      [DATA_W-1:0]    dmem_wdata,
   output logic                      dmem_we,
   output logic                      dmem_re,
   input  wire logic [DATA_W-1:0]    dmem_rdata,
   // I/O register space
   output logic      [IO_ADDR_W-1:0] io_addr,
   output logic      [DATA_W-1:0]    io_wdata,
   output logic                      io_we,
   output logic                      io_re,
   input  wire logic [DATA_W-1:0]    io_rdata,
   // Core control
   output logic                      sleep_req,
   output logic                      wdt_restart,
   output logic                      break_req,
   output logic                      irq_enable,
   output logic                      busy
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   exec_state_type      state_reg;
   exec_state_type      state_next;
   logic [31:0]         cmd_reg;
   logic [DATA_W-1:0]   flags_reg;
   logic [ADDR_W-1:0]   x_reg;
   logic [ADDR_W-1:0]   y_reg;
   logic [ADDR_W-1:0]   z_reg;
   logic [ADDR_W-1:0]   sp_reg;
   logic [ADDR_W-1:0]   addr_reg;
   logic [ADDR_W-1:0]   addr_next;
   logic [31:0]         prdata_reg;
   logic                illegal_reg;
   logic [1:0]          len_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode.

   function automatic logic in_rf_window(input logic [APB_AW-1:0] a);
      in_rf_window = (a & RF_SEL_MASK) == OFF_RF_BASE;
   endfunction

   wire                 apb_setup  = psel & ~penable;
   wire                 apb_access = psel & penable;
   wire                 wr_acc     = apb_access & pwrite;
   wire                 hit_cmd    = paddr == OFF_CMD;
   wire                 hit_state  = paddr == OFF_STATE;
   wire                 hit_flags  = paddr == OFF_FLAGS;
   wire                 hit_x      = paddr == OFF_XPTR;
   wire                 hit_y      = paddr == OFF_YPTR;
   wire                 hit_z      = paddr == OFF_ZPTR;
   wire                 hit_sp     = paddr == OFF_SP;
   wire                 hit_rf     = in_rf_window(paddr);
   wire [RF_IDX_W-1:0]  apb_rf_idx = paddr[RF_IDX_LSB +: RF_IDX_W];
   wire                 writable   = hit_cmd | hit_flags | hit_x | hit_y | hit_z | hit_sp
                                     | hit_rf;
   wire                 mapped     = writable | hit_state;
   wire                 refused    = wr_acc & busy & writable;
   wire                 sw_wr      = wr_acc & ~busy;
   wire                 start      = sw_wr & hit_cmd;

   assign busy    = state_reg != S_IDLE;
   assign pready  = 1'b1;
   assign pslverr = apb_access & (~mapped | refused);

   ////////////////////////////////////////////////////////////////////////////////
   // Command fields and opcode decode.

   wire [OP_W-1:0]      op      = cmd_reg[CMD_OP_LSB +: OP_W];
   wire [RF_IDX_W-1:0]  rd_idx  = cmd_reg[CMD_RD_LSB +: RF_IDX_W];
   wire [RF_IDX_W-1:0]  rr_idx  = cmd_reg[CMD_RR_LSB +: RF_IDX_W];
   wire [BIT_IDX_W-1:0] bit_idx = cmd_reg[CMD_BIT_LSB +: BIT_IDX_W];
   wire [PTR_SEL_W-1:0] ptr_sel = cmd_reg[CMD_PTR_LSB +: PTR_SEL_W];
   wire [DATA_W-1:0]    k_val   = cmd_reg[CMD_K_LSB +: DATA_W];
   wire [DATA_W-1:0]    mask    = bit_mask(bit_idx);

   wire op_copy  = op == OP_COPY;
   wire op_imm   = op == OP_IMM;
   wire op_rp    = op == OP_RP;
   wire op_ldinc = op == OP_RP_INC;
   wire op_lddec = op == OP_RP_DEC;
   wire op_wp    = op == OP_WP;
   wire op_stinc = op == OP_WP_INC;
   wire op_stdec = op == OP_WP_DEC;
   wire op_rdir  = op == OP_RDIR;
   wire op_wdir  = op == OP_WDIR;
   wire op_in    = op == OP_IN;
   wire op_out   = op == OP_OUT;
   wire op_push  = op == OP_PUSH;
   wire op_pop   = op == OP_POP;
   wire op_ioset = op == OP_IOSET;
   wire op_ioclr = op == OP_IOCLR;
   wire op_tsto  = op == OP_TSTORE;
   wire op_tld   = op == OP_TLOAD;
   wire op_fset  = op == OP_FSET;
   wire op_fclr  = op == OP_FCLR;

   logic two_cycle;
   logic known;

   op_timing u_timing
   (
      .op        (op),
      .two_cycle (two_cycle),
      .known     (known)
   );

   wire in_fetch = state_reg == S_FETCH;
   wire in_e1    = state_reg == S_EXEC1;
   wire in_e2    = state_reg == S_EXEC2;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: fetch reads operands, then one or two execute cycles.

   always_comb
   begin
      case (state_reg)
         S_IDLE:  state_next = start ? S_FETCH : S_IDLE;
         S_FETCH: state_next = S_EXEC1;
         S_EXEC1: state_next = two_cycle ? S_EXEC2 : S_IDLE;
         S_EXEC2: state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg   <= S_IDLE;
         cmd_reg     <= 32'h0000_0000;
         illegal_reg <= 1'b0;
         len_reg     <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (start)
         begin
            cmd_reg <= pwdata;
         end
         if (in_fetch)
         begin
            illegal_reg <= ~known;
            len_reg     <= two_cycle ? 2'h2 : 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [DATA_W-1:0]   rf_a_q;
   logic [DATA_W-1:0]   rf_b_q;
   logic [DATA_W-1:0]   ex_rf_data;
   logic                ex_rf_we;

   wire                 rf_we    = ex_rf_we | (sw_wr & hit_rf);
   wire [RF_IDX_W-1:0]  rf_waddr = busy ? rd_idx : apb_rf_idx;
   wire [DATA_W-1:0]    rf_wdata = busy ? ex_rf_data : pwdata[DATA_W-1:0];
   wire [RF_IDX_W-1:0]  rf_ra    = busy ? rd_idx : apb_rf_idx;

   gp_regfile
   #(
      .WIDTH (DATA_W),
      .DEPTH (RF_DEPTH),
      .AW    (RF_IDX_W)
   )
   u_regfile
   (
      .clk     (pclk),
      .we      (rf_we),
      .waddr   (rf_waddr),
      .wdata   (rf_wdata),
      .raddr_a (rf_ra),
      .raddr_b (rr_idx),
      .rdata_a (rf_a_q),
      .rdata_b (rf_b_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Data memory and stack accesses.

   wire [ADDR_W-1:0] ptr_val = (ptr_sel == PTR_X) ? x_reg :
                               (ptr_sel == PTR_Y) ? y_reg : z_reg;

   assign dmem_re    = (in_e1 & (op_rp | op_ldinc | op_rdir))           // [RULE9] [RULE13]
                       | (in_e2 & (op_lddec | op_pop));                   // [RULE10] [RULE17]
   assign dmem_we    = (in_e1 & (op_wp | op_stinc | op_wdir | op_push)) // [RULE11] [RULE14] [RULE16]
                       | (in_e2 & op_stdec);                              // [RULE12]
   assign dmem_addr  = addr_reg;
   assign dmem_wdata = rf_b_q;

   // Pre-decrement and pop addresses are formed at the end of the first
   // execute cycle so the access in the second cycle sees the moved pointer.
   assign addr_next = in_fetch ? ((op_rdir | op_wdir) ? k_val :          // [RULE13] [RULE14]
                                  op_push ? sp_reg : ptr_val) :          // [RULE16]
                      (in_e1 & (op_lddec | op_stdec)) ? ptr_val - PTR_STEP :  // [RULE10] [RULE12]
                      (in_e1 & op_pop) ? sp_reg + PTR_STEP : addr_reg;   // [RULE17]

   ////////////////////////////////////////////////////////////////////////////////
   // I/O space accesses; bit operations read and write back in one cycle.

   assign io_addr  = k_val[IO_ADDR_W-1:0];
   assign io_re    = in_e1 & (op_in | op_ioset | op_ioclr);              // [RULE15]
   assign io_we    = in_e1 & (op_out | op_ioset | op_ioclr);             // [RULE15]
   assign io_wdata = op_ioset ? (io_rdata | mask) :                      // [RULE1]
                     op_ioclr ? (io_rdata & ~mask) : rf_b_q;             // [RULE2]

   ////////////////////////////////////////////////////////////////////////////////
   // Register file write-back.

   assign ex_rf_we   = dmem_re | (in_e1 & (op_in | op_copy | op_imm | op_tld));  // [RULE21]
   assign ex_rf_data = dmem_re ? dmem_rdata :
                       op_in   ? io_rdata :                              // [RULE15]
                       op_copy ? rf_b_q :                                // [RULE21]
                       op_imm  ? k_val :                                 // [RULE21]
                       ((rf_a_q & ~mask) | (flags_reg[FLG_T] ? mask : 8'h00));  // [RULE4]

   ////////////////////////////////////////////////////////////////////////////////
   // Pointer and stack pointer updates.

   wire ptr_inc = (in_e2 & op_ldinc) | (in_e1 & op_stinc);              // [RULE9] [RULE11]
   wire ptr_dec = in_e1 & (op_lddec | op_stdec);                         // [RULE10] [RULE12]
   wire ptr_mov = ptr_inc | ptr_dec;
   wire [ADDR_W-1:0] ptr_new = ptr_inc ? ptr_val + PTR_STEP : ptr_val - PTR_STEP;
   wire [ADDR_W-1:0] sw_ptr  = pwdata[ADDR_W-1:0];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         x_reg    <= PTR_RESET;
         y_reg    <= PTR_RESET;
         z_reg    <= PTR_RESET;
         sp_reg   <= SP_RESET;
         addr_reg <= PTR_RESET;
      end
      else
      begin
         addr_reg <= addr_next;
         if (ptr_mov & (ptr_sel == PTR_X))
            x_reg <= ptr_new;
         else if (sw_wr & hit_x)
            x_reg <= sw_ptr;
         if (ptr_mov & (ptr_sel == PTR_Y))
            y_reg <= ptr_new;
         else if (sw_wr & hit_y)
            y_reg <= sw_ptr;
         if (ptr_mov & (ptr_sel == PTR_Z))
            z_reg <= ptr_new;
         else if (sw_wr & hit_z)
            z_reg <= sw_ptr;
         if (in_e2 & op_push)
            sp_reg <= sp_reg - PTR_STEP;                                 // [RULE16]
         else if (in_e1 & op_pop)
            sp_reg <= sp_reg + PTR_STEP;                                 // [RULE17]
         else if (sw_wr & hit_sp)
            sp_reg <= sw_ptr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags: only the addressed flag changes; data moves leave them alone.

   wire [DATA_W-1:0] t_mask    = bit_mask(BIT_IDX_W'(FLG_T));
   wire              t_src     = rf_b_q[bit_idx];
   wire [DATA_W-1:0] flags_set = (in_e1 & op_fset) ? mask : 8'h00;           // [RULE5] [RULE7] [RULE8]
   wire [DATA_W-1:0] flags_clr = (in_e1 & op_fclr) ? mask : 8'h00;           // [RULE6] [RULE22]
   wire [DATA_W-1:0] flags_bst = (in_e1 & op_tsto) ?
                                 ((flags_reg & ~t_mask) | (t_src ? t_mask : 8'h00)) :
                                 flags_reg;                                   // [RULE3]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_reg <= FLAGS_RESET;
      end
      else if (sw_wr & hit_flags)
      begin
         flags_reg <= pwdata[DATA_W-1:0];
      end
      else
      begin
         flags_reg <= (flags_bst | flags_set) & ~flags_clr;                  // [RULE5] [RULE6]
      end
   end

   assign irq_enable = flags_reg[FLG_I];

   ////////////////////////////////////////////////////////////////////////////////
   // Core control requests, one-cycle pulses in the execute cycle.

   assign sleep_req   = in_e1 & (op == OP_SLEEP);                        // [RULE18]
   assign wdt_restart = in_e1 & (op == OP_WDOG);                         // [RULE19]
   assign break_req   = in_e1 & (op == OP_HALT);                         // [RULE20]

   ////////////////////////////////////////////////////////////////////////////////
   // Read data: captured in the setup cycle, register file data from its port.

   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_cmd)
         rd_mux = cmd_reg;
      else if (hit_state)
         rd_mux = {26'h0, len_reg, 2'h0, illegal_reg, busy};
      else if (hit_flags)
         rd_mux = {24'h0, flags_reg};
      else if (hit_x)
         rd_mux = {24'h0, x_reg};
      else if (hit_y)
         rd_mux = {24'h0, y_reg};
      else if (hit_z)
         rd_mux = {24'h0, z_reg};
      else if (hit_sp)
         rd_mux = {24'h0, sp_reg};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0000_0000;
      else if (apb_setup)
         prdata_reg <= rd_mux;
   end

   assign prdata = hit_rf ? {24'h0, rf_a_q} : prdata_reg;

endmodule

// [bench/bit_xfer_props.sv]
`timescale 1ns/100ps
module bit_xfer_props
   import bit_xfer_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   // Execution outputs
   input wire logic              busy,
   input wire logic              dmem_we,
   input wire logic              dmem_re,
   input wire logic              io_we,
   input wire logic              sleep_req,
   input wire logic              wdt_restart,
   input wire logic              break_req,
   input wire logic              irq_enable
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   sequence s_start;
      $rose(busy);
   endsequence
   sequence s_run;
      busy [*2] ##1 (!busy or (busy ##1 !busy));
   endsequence
   sequence s_last;
      busy ##1 !busy;
   endsequence
   property p_len;
      s_start |-> s_run;
   endproperty
   property p_sleep;
      sleep_req |-> s_last;
   endproperty
   property p_wdt;
      wdt_restart |-> s_last;
   endproperty
   property p_brk;
      break_req |-> s_last;
   endproperty
   property p_io;
      io_we |-> s_last;
   endproperty
   property p_dwe;
      dmem_we |=> !dmem_we;
   endproperty
   property p_dre;
      dmem_re |-> busy ##1 !dmem_re;
   endproperty
   property p_irq;
      $changed(irq_enable) |-> $past(busy) || $past(psel && penable && pwrite && paddr == OFF_FLAGS);
   endproperty
   a_len: assert property (p_len) else $error("busy length wrong");
   a_sleep: assert property (p_sleep) else $error("sleep pulse wrong");
   a_wdt: assert property (p_wdt) else $error("watchdog pulse wrong");
   a_brk: assert property (p_brk) else $error("break pulse wrong");
   a_io: assert property (p_io) else $error("io write timing wrong");
   a_dwe: assert property (p_dwe) else $error("store strobe too long");
   a_dre: assert property (p_dre) else $error("load strobe wrong");
   a_irq: assert property (p_irq) else $error("irq flag changed alone");
endmodule

bind bit_xfer_exec bit_xfer_props u_bit_xfer_props (.*);

// [bench/mem_io_model.sv]
`timescale 1ns/100ps
module mem_io_model
(
   // Clock
   input  wire logic       pclk,
   // Data memory
   input  wire logic [7:0] dmem_addr,
   input  wire logic [7:0] dmem_wdata,
   input  wire logic       dmem_we,
   input  wire logic       dmem_re,
   output logic      [7:0] dmem_rdata,
   // I/O space
   input  wire logic [5:0] io_addr,
   input  wire logic [7:0] io_wdata,
   input  wire logic       io_we,
   input  wire logic       io_re,
   output logic      [7:0] io_rdata
);
   logic [7:0] mem [256];
   logic [7:0] io [64];
   // Reads are asynchronous; outside a strobe the bus shows the inverse value.
   assign dmem_rdata = dmem_re ? mem[dmem_addr] : ~mem[dmem_addr];
   assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
   always @(posedge pclk)
   begin
      if (dmem_we)
         mem[dmem_addr] <= dmem_wdata;
      if (io_we)
         io[io_addr] <= io_wdata;
   end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   import bit_xfer_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic        e, pready, pslverr, dmem_we, dmem_re, io_we, io_re;
   logic        sleep_req, wdt_restart, break_req, irq_enable, busy;
   logic [7:0]  dmem_addr, dmem_wdata, dmem_rdata, io_wdata, io_rdata, v, w, fl;
   logic [5:0]  io_addr;
   logic [7:0]  rv [16];
   int          fail_count = 0, n_tests = 0, ns = 0, nw = 0, nb = 0;
   bit_xfer_exec u_bit_xfer_exec (.*);
   mem_io_model u_mem_io_model (.*);
   always #25 pclk = ~pclk;
   always @(posedge pclk)
   begin
      ns <= ns + sleep_req;
      nw <= nw + wdt_restart;
      nb <= nb + break_req;
   end
   ////////////////////////////////////////
   function automatic logic [31:0] cw(logic [5:0] op, int rd, rs, b,
      int pt, k);
      return {k[7:0], 2'h0, pt[1:0], 1'b0, b[2:0], rs[3:0], rd[3:0], 2'h0, op};
   endfunction
   function automatic logic [7:0] wb(logic [7:0] x, logic [2:0] b, logic t);
      x[b] = t;
      return x;
   endfunction
   task automatic chk(input logic [31:0] s, x);
      n_tests++;
      if (s !== x)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tmo;
      fail_count++;
      final_report();
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
         tmo();
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic poll(input int len);
      int i;
      for (i = 0; i < 20; i++)
      begin
         apb(1'b0, OFF_STATE, 0);
         if (r[STATE_BUSY] === 1'b0)
            break;
      end
      if (i == 20)
         tmo();
      chk(r[STATE_LEN_LSB +: 2], len);
   endtask
   task automatic run(input logic [31:0] c, input int len);
      apb(1'b1, OFF_CMD, c);
      poll(len);
   endtask
   task automatic rchk(input int i);
      apb(1'b0, OFF_RF_BASE + 8'(i << RF_IDX_LSB), 0);
      chk(r, {24'h0, rv[i]});
   endtask
   ////////////////////////////////////////
   initial
   begin
      v = 8'($urandom(62));
      fl = 8'h00;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFF_SP, 0);
      chk(r, 32'hff);
      run(cw(OP_IDLE, 0, 0, 0, 0, 0), 1);
      for (int p = 0; p < 2; p++)
         for (int b = 0; b < 8; b++)
         begin
            run(cw(p ? OP_FCLR : OP_FSET, 0, 0, 3'(b), 0, 0), 1);
            fl = wb(fl, 3'(b), p == 0);
            apb(1'b0, OFF_FLAGS, 0);
            chk(r, {24'h0, fl});
            chk(irq_enable, fl[FLG_I]);
         end
      for (int i = 0; i < 16; i++)
      begin
         rv[i] = 8'($urandom);
         run(cw(OP_IMM, 4'(i), 0, 0, 0, rv[i]), 1);
         rchk(i);
      end
      run(cw(OP_COPY, 1, 2, 0, 0, 0), 1);
      rv[1] = rv[2];
      rchk(1);
      v = 8'($urandom);
      run(cw(OP_WDIR, 0, 3, 0, 0, v), 1);
      chk(u_mem_io_model.mem[v], rv[3]);
      run(cw(OP_RDIR, 4, 0, 0, 0, v), 1);
      rv[4] = rv[3];
      rchk(4);
      for (int q = 0; q < 3; q++)
      begin
         v = (q == 0) ? 8'h00 : 8'($urandom);
         apb(1'b1, OFF_XPTR + 8'(q * 4), {24'h0, v});
         run(cw(OP_WP_INC, 0, 5, 0, q, 0), 1);
         chk(u_mem_io_model.mem[v], rv[5]);
         apb(1'b0, OFF_XPTR + 8'(q * 4), 0);
         chk(r, {24'h0, 8'(v + 1)});
         run(cw(OP_WP_DEC, 0, 6, 0, q, 0), 2);
         chk(u_mem_io_model.mem[v], rv[6]);
         run(cw(OP_RP_INC, 7, 0, 0, q, 0), 2);
         run(cw(OP_RP_DEC, 8, 0, 0, q, 0), 2);
         run(cw(OP_RP, 9, 0, 0, q, 0), 1);
         apb(1'b0, OFF_XPTR + 8'(q * 4), 0);
         chk(r, {24'h0, v});
         rv[7] = rv[6];
         rv[8] = rv[6];
         rv[9] = rv[6];
         rchk(7);
         rchk(8);
         rchk(9);
         run(cw(OP_WP, 0, 4, 0, q, 0), 1);
         chk(u_mem_io_model.mem[v], rv[4]);
      end
      run(cw(OP_PUSH, 0, 10, 0, 0, 0), 2);
      chk(u_mem_io_model.mem[8'hff], rv[10]);
      apb(1'b0, OFF_SP, 0);
      chk(r, 32'hfe);
      run(cw(OP_POP, 11, 0, 0, 0, 0), 2);
      rv[11] = rv[10];
      rchk(11);
      v = 8'($urandom % 64);
      run(cw(OP_OUT, 0, 12, 0, 0, v), 1);
      chk(u_mem_io_model.io[v], rv[12]);
      run(cw(OP_IN, 13, 0, 0, 0, v), 1);
      rv[13] = rv[12];
      rchk(13);
      w = 8'($urandom % 8);
      run(cw(OP_IOSET, 0, 0, w[2:0], 0, v), 1);
      chk(u_mem_io_model.io[v], wb(rv[12], w[2:0], 1'b1));
      run(cw(OP_IOCLR, 0, 0, w[2:0], 0, v), 1);
      chk(u_mem_io_model.io[v], wb(rv[12], w[2:0], 1'b0));
      apb(1'b0, OFF_FLAGS, 0);
      chk(r, 0);
      run(cw(OP_TSTORE, 0, 14, w[2:0], 0, 0), 1);
      fl = wb(8'h00, 3'(FLG_T), rv[14][w[2:0]]);
      apb(1'b0, OFF_FLAGS, 0);
      chk(r, {24'h0, fl});
      run(cw(OP_TLOAD, 15, 0, 3'(w + 1), 0, 0), 1);
      rv[15] = wb(rv[15], 3'(w + 1), fl[FLG_T]);
      rchk(15);
      run(cw(OP_SLEEP, 0, 0, 0, 0, 0), 1);
      run(cw(OP_WDOG, 0, 0, 0, 0, 0), 1);
      run(cw(OP_HALT, 0, 0, 0, 0, 0), 1);
      chk(ns, 1);
      chk(nw, 1);
      chk(nb, 1);
      run(cw(6'h3f, 0, 0, 0, 0, 0), 1);
      chk(r[STATE_ILLEGAL], 1);
      apb(1'b1, OFF_CMD, cw(OP_PUSH, 0, 0, 0, 0, 0));
      apb(1'b1, OFF_CMD, cw(OP_IDLE, 0, 0, 0, 0, 0));
      chk(e, 1);
      poll(2);
      apb(1'b0, 8'h20, 0);
      chk(e, 1);
      $display("test sequence done");
      final_report();
   end
endmodule
